/* File: rtl/rx_irq_pkg.sv */
// shared constants for the receiver interrupt source and flag block
package rx_irq_pkg;

    // register indexes; byte address is four times the index
    localparam int IDX_IRQ_SEL      = 13;
    localparam int IDX_FILL_CTRL    = 14;
    localparam int IDX_STRENGTH_THR = 15;

    localparam logic [7:0] ADDR_IRQ_SEL      = 8'(4 * IDX_IRQ_SEL);
    localparam logic [7:0] ADDR_FILL_CTRL    = 8'(4 * IDX_FILL_CTRL);
    localparam logic [7:0] ADDR_STRENGTH_THR = 8'(4 * IDX_STRENGTH_THR);
    localparam logic [7:0] ADDR_CFG          = 8'h40;
    localparam logic [7:0] ADDR_EV_STATUS    = 8'h44;
    localparam logic [7:0] ADDR_EV_MASK      = 8'h48;

    // irq_select_and_fifo_flags fields
    localparam int SEL0_LSB   = 6;
    localparam int SEL1_LSB   = 4;
    localparam int FULL_BIT   = 2;
    localparam int NEMPTY_BIT = 1;
    localparam int OVR_BIT    = 0;

    // fill_control_and_event_flags fields
    localparam int FILL_METHOD_BIT = 7;
    localparam int FILL_BIT        = 6;
    localparam int SPARE_LSB       = 3;
    localparam int STRENGTH_BIT    = 2;
    localparam int LOCK_BIT        = 1;
    localparam int LOCK_EN_BIT     = 0;

    // configuration register fields
    localparam int MODE_LSB   = 0;
    localparam int SIZE_LSB   = 2;
    localparam int THRESH_LSB = 4;
    localparam int AFILT_BIT  = 10;

    // reset values
    localparam logic [1:0] SEL_RST       = 2'h0;
    localparam logic [7:0] FILL_CTRL_RST = 8'h01;
    localparam logic [7:0] THR_RST       = 8'h00;
    localparam logic [1:0] MODE_RST      = 2'h0;
    localparam logic [1:0] SIZE_RST      = 2'h0;
    localparam logic [5:0] THRESH_RST    = 6'h0F;

    // bytes per step of the fifo size field
    localparam int FIFO_STEP = 16;

    // event status bits
    localparam int EV_OVERRUN  = 0;
    localparam int EV_FULL     = 1;
    localparam int EV_STRENGTH = 2;
    localparam int EV_SYNC     = 3;
    localparam int NUM_EV      = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {MODE_CONT, MODE_BUF, MODE_PKT} path_mode_t;

endpackage

/* File: rtl/level_sync2.sv */
// two-stage synchroniser for levels entering from outside the clock domain
`timescale 1ns/1ns
module level_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;

    // first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end
endmodule

/* File: rtl/rx_irq_flags.sv */
// receiver interrupt source selection, fifo flags and event flags
// Notes on behaviour
// - continuous: line0 code 01 strength, else sync
// - buffered: line0 none, byte, not-empty, sync
// - packet: line0 payload, byte, not-empty, sync/address
// - continuous: line1 always recovered bit clock
// - buffered/packet: line1 none/crc, full, strength, threshold
// - fifo sources stay valid in standby too
// - full flag high at configured capacity
// - not-empty flag low when fifo empty
// - overrun sets flag; write one clears, flushes
// - fill method: auto on sync, or manual
// - auto fill bit; write one re-arms unless overrun
// - strength flag set above threshold, write-one clears
// - lock flag set on lock, held; write-one clears
// - lock enable drives pin, else pin released
// - eight-bit strength threshold register, reset zero
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module rx_irq_flags
    import rx_irq_pkg::*;
#(
    parameter int FIFO_MAX = 64,
    parameter int LEVEL_W  = 7
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [7:0]         araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    input  wire logic [LEVEL_W-1:0] fifo_level,
    input  wire logic               fifo_write_req,
    input  wire logic               sync_detect,
    input  wire logic               byte_written,
    input  wire logic               payload_ready,
    input  wire logic               address_match,
    input  wire logic               crc_ok,
    input  wire logic [7:0]         rssi_value,
    input  wire logic               recovered_bit_clock,
    input  wire logic               pll_lock_raw,
    output logic                    irq_0,
    output logic                    irq_1,
    output logic                    irq,
    output logic                    fifo_flush,
    output logic                    fifo_fill_enable,
    output logic                    lock_pin_out,
    output logic                    lock_pin_oe
);
    if (FIFO_MAX > (1 << LEVEL_W) - 1 || FIFO_MAX < 4 * FIFO_STEP) begin : g_bad_width
        $error("fifo level width cannot hold the largest fifo size");
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]        aw_addr_reg;
    logic              aw_hold_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              w_hold_reg;
    logic              wr_en;
    logic [31:0]       rdata_next;
    logic              rd_hit;
    logic              wr_hit;
    logic              bresp_err_reg;
    logic [1:0]        sel0_reg;
    logic [1:0]        sel1_reg;
    logic              overrun_reg;
    logic              full_reg;
    logic              nempty_reg;
    logic              fill_method_reg;
    logic              fill_reg;
    logic [1:0]        spare_reg;
    logic              strength_event_flag;
    logic              lock_flag_reg;
    logic              lock_en_reg;
    logic [7:0]        strength_event_threshold;
    logic [1:0]        mode_reg;
    logic [1:0]        size_reg;
    logic [5:0]        thresh_reg;
    logic              afilt_reg;
    logic [NUM_EV-1:0] ev_status_reg;
    logic [NUM_EV-1:0] ev_mask_reg;
    logic [NUM_EV-1:0] ev_set;
    logic              lock_sync;
    logic              wr_sel;
    logic              wr_fill;
    logic              ovr_clr;
    logic              full_now;
    logic              thresh_hit;
    logic              strength_hit;
    logic              auto_fill;
    logic              irq_0_next;
    logic              irq_1_next;
    logic [LEVEL_W-1:0] capacity;
    path_mode_t        mode;

    level_sync2 #(.WIDTH(1)) u_lock_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pll_lock_raw),
        .sync_out (lock_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // write path: address and data taken in either order, response after both
    assign awready = !aw_hold_reg && !bvalid;
    assign wready  = !w_hold_reg && !bvalid;
    assign wr_en   = aw_hold_reg && w_hold_reg && !bvalid;
    assign bresp   = bresp_err_reg ? RESP_SLVERR : RESP_OKAY; // unmapped writes dropped, but flagged

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_hold_reg  <= 1'b0;
            wdata_reg   <= 32'h00000000;
            wstrb_reg   <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end else if (wr_en) begin
                aw_hold_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= wdata;
                wstrb_reg  <= wstrb;
            end else if (wr_en) begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        case (aw_addr_reg)
            ADDR_IRQ_SEL, ADDR_FILL_CTRL, ADDR_STRENGTH_THR: wr_hit = 1'b1;
            ADDR_CFG, ADDR_EV_STATUS, ADDR_EV_MASK:          wr_hit = 1'b1;
            default:                                         wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid        <= 1'b0;
            bresp_err_reg <= 1'b0;
        end else if (wr_en) begin
            bvalid        <= 1'b1;
            bresp_err_reg <= !wr_hit;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path: one cycle from address to data
    assign arready = !rvalid;

    always_comb begin
        rdata_next = 32'h00000000;
        rd_hit     = 1'b1;
        case (araddr)
            ADDR_IRQ_SEL:      rdata_next[7:0] = {sel0_reg, sel1_reg, 1'b0, full_reg, nempty_reg, overrun_reg};
            ADDR_FILL_CTRL:    rdata_next[7:0] = {fill_method_reg, fill_reg, 1'b0, spare_reg,
                                                  strength_event_flag, lock_flag_reg, lock_en_reg};
            ADDR_STRENGTH_THR: rdata_next[7:0] = strength_event_threshold;
            ADDR_CFG:          rdata_next[10:0] = {afilt_reg, thresh_reg, size_reg, mode_reg};
            ADDR_EV_STATUS:    rdata_next[NUM_EV-1:0] = ev_status_reg;
            ADDR_EV_MASK:      rdata_next[NUM_EV-1:0] = ev_mask_reg;
            default:           rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rdata_next;
            rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration and selector registers
    assign wr_sel  = wr_en && wstrb_reg[0] && aw_addr_reg == ADDR_IRQ_SEL;
    assign wr_fill = wr_en && wstrb_reg[0] && aw_addr_reg == ADDR_FILL_CTRL;
    assign ovr_clr = wr_sel && wdata_reg[OVR_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel0_reg <= SEL_RST;
            sel1_reg <= SEL_RST;
        end else if (wr_sel) begin
            sel0_reg <= wdata_reg[SEL0_LSB +: 2];
            sel1_reg <= wdata_reg[SEL1_LSB +: 2];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strength_event_threshold <= THR_RST;
        end else if (wr_en && wstrb_reg[0] && aw_addr_reg == ADDR_STRENGTH_THR) begin
            strength_event_threshold <= wdata_reg[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg   <= MODE_RST;
            size_reg   <= SIZE_RST;
            thresh_reg <= THRESH_RST;
            afilt_reg  <= 1'b0;
        end else if (wr_en && aw_addr_reg == ADDR_CFG) begin
            if (wstrb_reg[0]) begin
                mode_reg       <= wdata_reg[MODE_LSB +: 2];
                size_reg       <= wdata_reg[SIZE_LSB +: 2];
                thresh_reg[3:0] <= wdata_reg[THRESH_LSB +: 4];
            end
            if (wstrb_reg[1]) begin
                thresh_reg[5:4] <= wdata_reg[THRESH_LSB + 4 +: 2];
                afilt_reg       <= wdata_reg[AFILT_BIT];
            end
        end
    end

    // packet mode ignores the low mode bit
    assign mode = mode_reg[1] ? MODE_PKT : (mode_reg[0] ? MODE_BUF : MODE_CONT);

    ////////////////////////////////////////////////////////////////////////////
    // fifo level flags; no gating by receive state, so they hold in standby
    assign capacity   = LEVEL_W'(FIFO_STEP * (int'(size_reg) + 1));
    assign full_now   = fifo_level >= capacity;
    assign thresh_hit = fifo_level > LEVEL_W'(thresh_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            full_reg   <= 1'b0;
            nempty_reg <= 1'b0;
        end else begin
            full_reg   <= full_now;
            nempty_reg <= fifo_level != '0;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overrun_reg <= 1'b0;
            fifo_flush  <= 1'b0;
        end else begin
            fifo_flush <= ovr_clr;
            if (fifo_write_req && full_now) begin
                overrun_reg <= 1'b1;
            end else if (ovr_clr) begin
                overrun_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fill control
    assign auto_fill = mode == MODE_BUF && !fill_method_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fill_method_reg <= FILL_CTRL_RST[FILL_METHOD_BIT];
            fill_reg        <= FILL_CTRL_RST[FILL_BIT];
            spare_reg       <= FILL_CTRL_RST[SPARE_LSB +: 2];
        end else begin
            if (wr_fill) begin
                fill_method_reg <= wdata_reg[FILL_METHOD_BIT];
                spare_reg       <= wdata_reg[SPARE_LSB +: 2];
            end
            if (auto_fill && sync_detect) begin
                fill_reg <= 1'b1;
            end else if (wr_fill && fill_method_reg) begin
                fill_reg <= wdata_reg[FILL_BIT];
            end else if (wr_fill && wdata_reg[FILL_BIT] && !overrun_reg) begin
                fill_reg <= 1'b0;
            end
        end
    end

    // other modes handle their own storage gating
    assign fifo_fill_enable = mode != MODE_BUF || fill_reg;

    ////////////////////////////////////////////////////////////////////////////
    // strength and lock flags
    assign strength_hit = rssi_value > strength_event_threshold;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strength_event_flag <= FILL_CTRL_RST[STRENGTH_BIT];
            lock_flag_reg       <= FILL_CTRL_RST[LOCK_BIT];
            lock_en_reg         <= FILL_CTRL_RST[LOCK_EN_BIT];
        end else begin
            if (strength_hit) begin
                strength_event_flag <= 1'b1;
            end else if (wr_fill && wdata_reg[STRENGTH_BIT]) begin
                strength_event_flag <= 1'b0;
            end
            if (lock_sync) begin
                lock_flag_reg <= 1'b1;
            end else if (wr_fill && wdata_reg[LOCK_BIT]) begin
                lock_flag_reg <= 1'b0;
            end
            if (wr_fill) begin
                lock_en_reg <= wdata_reg[LOCK_EN_BIT];
            end
        end
    end

    // pin released rather than driven low so a board pull sets its idle level
    assign lock_pin_out = lock_flag_reg;
    assign lock_pin_oe  = lock_en_reg;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt line source selection
    always_comb begin
        irq_0_next = 1'b0;
        irq_1_next = 1'b0;
        case (mode)
            MODE_CONT: begin
                irq_0_next = (sel0_reg == 2'h1) ? strength_event_flag : sync_detect;
                irq_1_next = recovered_bit_clock;
            end
            MODE_BUF: begin
                case (sel0_reg)
                    2'h1:    irq_0_next = byte_written;
                    2'h2:    irq_0_next = nempty_reg;
                    2'h3:    irq_0_next = sync_detect;
                    default: irq_0_next = 1'b0;
                endcase
            end
            MODE_PKT: begin
                case (sel0_reg)
                    2'h1:    irq_0_next = byte_written;
                    2'h2:    irq_0_next = nempty_reg;
                    2'h3:    irq_0_next = afilt_reg ? address_match : sync_detect;
                    default: irq_0_next = payload_ready;
                endcase
            end
            default: irq_0_next = 1'b0;
        endcase
        if (mode != MODE_CONT) begin
            case (sel1_reg)
                2'h1:    irq_1_next = full_reg;
                2'h2:    irq_1_next = strength_event_flag;
                2'h3:    irq_1_next = thresh_hit;
                default: irq_1_next = (mode == MODE_PKT) && crc_ok;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_0 <= 1'b0;
            irq_1 <= 1'b0;
        end else begin
            irq_0 <= irq_0_next;
            irq_1 <= irq_1_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event status, write-one-to-clear, masked onto one line
    assign ev_set[EV_OVERRUN]  = fifo_write_req && full_now;
    assign ev_set[EV_FULL]     = full_now && !full_reg;
    assign ev_set[EV_STRENGTH] = strength_hit && !strength_event_flag;
    assign ev_set[EV_SYNC]     = sync_detect;

    for (genvar i = 0; i < NUM_EV; i++) begin : g_ev
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ev_status_reg[i] <= 1'b0;
            end else if (ev_set[i]) begin
                ev_status_reg[i] <= 1'b1;
            end else if (wr_en && wstrb_reg[0] && aw_addr_reg == ADDR_EV_STATUS && wdata_reg[i]) begin
                ev_status_reg[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_mask_reg <= '0;
            irq         <= 1'b0;
        end else begin
            if (wr_en && wstrb_reg[0] && aw_addr_reg == ADDR_EV_MASK) begin
                ev_mask_reg <= wdata_reg[NUM_EV-1:0];
            end
            irq <= |(ev_status_reg & ev_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_fill_write_one;
        wr_fill && wdata_reg[FILL_BIT] && !fill_method_reg;
    endsequence
    sequence s_lock_disable_write;
        wr_fill && !wdata_reg[LOCK_EN_BIT];
    endsequence

    a_line0_cont_sel:   assert property ((mode == MODE_CONT && sel0_reg != 2'h1) |=> irq_0 == $past(sync_detect))
        else $error("line0 not sync in continuous mode");
    a_line0_buf_none:   assert property ((mode == MODE_BUF && sel0_reg == 2'h0) |=> !irq_0)
        else $error("line0 active with no source");
    a_line0_pkt_addr:   assert property ((mode == MODE_PKT && sel0_reg == 2'h3 && afilt_reg) |=>
                                         irq_0 == $past(address_match))
        else $error("line0 not address match");
    a_line1_bit_clock:  assert property ((mode == MODE_CONT) |=> irq_1 == $past(recovered_bit_clock))
        else $error("line1 not bit clock");
    a_line1_full:       assert property ((mode != MODE_CONT && sel1_reg == 2'h1 && full_now) |=> ##1 irq_1)
        else $error("line1 missed fifo full");
    a_full_flag:        assert property ((fifo_level == capacity && $stable(fifo_level)) |=> full_reg)
        else $error("full flag low at capacity");
    a_empty_flag:       assert property ((fifo_level == '0) |=> !nempty_reg)
        else $error("not-empty flag high when empty");
    a_overrun_flush:    assert property (ovr_clr && !(fifo_write_req && full_now) |=> !overrun_reg && fifo_flush)
        else $error("overrun clear without flush");
    a_overrun_set:      assert property ((fifo_write_req && full_now) |=> overrun_reg [*1] ##1 1'b1)
        else $error("overrun flag not set");
    a_fill_start:       assert property ((auto_fill && sync_detect) |=> fill_reg)
        else $error("fill not started on sync");
    a_fill_rearm_block: assert property ((s_fill_write_one and overrun_reg) |=> fill_reg == $past(fill_reg) || fill_reg)
        else $error("fill cleared while overrun");
    a_strength_set:     assert property (strength_hit |=> strength_event_flag)
        else $error("strength flag not set");
    a_lock_release:     assert property (s_lock_disable_write |=> !lock_pin_oe)
        else $error("lock pin still driven");
    a_write_answer:     assert property ((awvalid && awready && wvalid && wready) |-> ##[1:2] bvalid)
        else $error("write response late");
endmodule

/* File: tb/host_model.sv */
// host side model watching the lock pin
`timescale 1ns/1ns
module host_model (
    input  wire logic aclk,
    input  wire logic lock_pin_out,
    input  wire logic lock_pin_oe,
    output logic      lock_seen = 1'b0
);
    logic last_drv = 1'b0;
    // no pull on the pin: a released pin reads as the inverse of its last driven level
    always @(posedge aclk) begin
        if (lock_pin_oe) last_drv <= lock_pin_out;
        lock_seen <= lock_pin_oe ? lock_pin_out : ~last_drv;
    end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the receiver interrupt flag block
`timescale 1ns/1ns
module testbench;
import rx_irq_pkg::*;
logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic [7:0] awaddr = 0, araddr = 0, rssi_value = 0;
logic [31:0] wdata = 0, rd_data;
logic [3:0] wstrb = 4'hF;
logic [6:0] fifo_level = 0;
logic [1:0] resp;
logic fifo_write_req = 0, sync_detect = 0, payload_ready = 0, crc_ok = 0, recovered_bit_clock = 0, pll_lock_raw = 0;
logic byte_written = 0, address_match = 0;
wire awready, wready, bvalid, arready, rvalid, irq_0, irq_1, irq, fifo_flush, fifo_fill_enable;
wire lock_pin_out, lock_pin_oe, lock_seen;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
int n_errors = 0, checks = 0, n_flush = 0;
rx_irq_flags DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .fifo_level, .fifo_write_req,
    .sync_detect, .byte_written, .payload_ready, .address_match, .crc_ok, .rssi_value,
    .recovered_bit_clock, .pll_lock_raw, .irq_0, .irq_1, .irq, .fifo_flush, .fifo_fill_enable, .lock_pin_out,
    .lock_pin_oe);
host_model host (.aclk, .lock_pin_out, .lock_pin_oe, .lock_seen);
initial forever #25 aclk = ~aclk;
always @(posedge aclk) if (fifo_flush === 1'b1) n_flush++;
////////////////////////////////////////////////////////////////////////////////
task give_verdict;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
        n_errors++;
        $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
endtask
task tick(input int n);
    repeat (n) @(posedge aclk);
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
        @(posedge aclk);
        if (awready) awvalid <= 0;
        if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 0;
    // let the register update land before callers look at outputs
    @(posedge aclk);
endtask
task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
        @(posedge aclk);
        if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    rd_data = rdata;
    resp = rresp;
    rready <= 0;
endtask
task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, rd_data);
endtask
task pulse_sync;
    @(posedge aclk) sync_detect <= 1;
    @(posedge aclk) sync_detect <= 0;
    tick(1);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    give_verdict;
end
initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rchk("fill_reg", ADDR_FILL_CTRL, 32'h01);
    rchk("thr_reg", ADDR_STRENGTH_THR, 32'h00);
    rd(8'h50);
    chk("unmapped", RESP_SLVERR, 32'(resp));
    wr(8'h50, 32'h0);
    chk("unmapped_wr", RESP_SLVERR, 32'(resp));
    $display("test reset done");
    recovered_bit_clock <= 1;
    tick(2);
    chk("irq_1", 1, 32'(irq_1));
    pulse_sync;
    chk("irq_0", 1, 32'(irq_0));
    wr(ADDR_STRENGTH_THR, 32'h10);
    chk("bresp", RESP_OKAY, 32'(resp));
    rssi_value <= 8'h20;
    wr(ADDR_IRQ_SEL, 32'h40);
    chk("irq_0", 1, 32'(irq_0));
    rchk("fill_reg", ADDR_FILL_CTRL, 32'h05);
    rssi_value <= 8'h10;
    wr(ADDR_FILL_CTRL, 32'h05);
    rchk("fill_reg", ADDR_FILL_CTRL, 32'h01);
    $display("test continuous done");
    wr(ADDR_CFG, 32'h0F1);
    byte_written <= 1;
    tick(2);
    chk("irq_0", 1, 32'(irq_0));
    wr(ADDR_IRQ_SEL, 32'h00);
    chk("irq_0", 0, 32'(irq_0));
    byte_written <= 0;
    wr(ADDR_IRQ_SEL, 32'h80);
    chk("fill_en", 0, 32'(fifo_fill_enable));
    fifo_level <= 1;
    tick(3);
    chk("irq_0", 1, 32'(irq_0));
    chk("irq_1", 0, 32'(irq_1));
    pulse_sync;
    chk("fill_en", 1, 32'(fifo_fill_enable));
    wr(ADDR_FILL_CTRL, 32'h41);
    chk("fill_en", 0, 32'(fifo_fill_enable));
    wr(ADDR_FILL_CTRL, 32'h81);
    wr(ADDR_FILL_CTRL, 32'hC1);
    chk("fill_en", 1, 32'(fifo_fill_enable));
    wr(ADDR_FILL_CTRL, 32'h81);
    chk("fill_en", 0, 32'(fifo_fill_enable));
    fifo_level <= 0;
    rchk("sel_reg", ADDR_IRQ_SEL, 32'h80);
    $display("test buffered done");
    wr(ADDR_IRQ_SEL, 32'h90);
    fifo_level <= 16;
    tick(3);
    chk("irq_1", 1, 32'(irq_1));
    wr(ADDR_IRQ_SEL, 32'hB0);
    chk("irq_1", 1, 32'(irq_1));
    fifo_level <= 15;
    tick(2);
    chk("irq_1", 0, 32'(irq_1));
    fifo_level <= 16;
    wr(ADDR_EV_MASK, 32'h01);
    @(posedge aclk) fifo_write_req <= 1;
    @(posedge aclk) fifo_write_req <= 0;
    tick(2);
    chk("irq", 1, 32'(irq));
    rchk("sel_reg", ADDR_IRQ_SEL, 32'hB7);
    wr(ADDR_FILL_CTRL, 32'h01);
    pulse_sync;
    wr(ADDR_FILL_CTRL, 32'h41);
    chk("fill_en", 1, 32'(fifo_fill_enable));
    wr(ADDR_IRQ_SEL, 32'hB1);
    tick(2);
    chk("flushes", 1, 32'(n_flush));
    rchk("sel_reg", ADDR_IRQ_SEL, 32'hB6);
    wr(ADDR_FILL_CTRL, 32'h41);
    chk("fill_en", 0, 32'(fifo_fill_enable));
    wr(ADDR_EV_STATUS, 32'h0F);
    tick(1);
    chk("irq", 0, 32'(irq));
    $display("test overrun done");
    wr(ADDR_CFG, 32'h0F2);
    wr(ADDR_IRQ_SEL, 32'h00);
    payload_ready <= 1;
    crc_ok <= 1;
    pll_lock_raw <= 1;
    tick(5);
    chk("irq_0", 1, 32'(irq_0));
    chk("irq_1", 1, 32'(irq_1));
    chk("lock_pin", 1, 32'(lock_seen));
    wr(ADDR_FILL_CTRL, 32'h02);
    chk("lock_oe", 0, 32'(lock_pin_oe));
    chk("lock_pin", 0, 32'(lock_seen));
    rchk("fill_reg", ADDR_FILL_CTRL, 32'h02);
    pll_lock_raw <= 0;
    tick(3);
    wr(ADDR_FILL_CTRL, 32'h02);
    rchk("fill_reg", ADDR_FILL_CTRL, 32'h00);
    wr(ADDR_CFG, 32'h4F2);
    wr(ADDR_IRQ_SEL, 32'hC0);
    chk("irq_0", 0, 32'(irq_0));
    address_match <= 1;
    tick(2);
    chk("irq_0", 1, 32'(irq_0));
    $display("test packet done");
    give_verdict;
end
endmodule
